//--- bench/spcb_remote_peer.sv
// Purpose: remote asynchronous serial peer
// Assumes: p clocks per bit; line idles high
// Notes: slave clock input stands still at one
`timescale 1ns/1ps
`default_nettype none
module spcb_remote_peer (
  input wire logic clk,
  input wire logic line,
  output logic dt_in,
  output logic ck_in
);
  initial begin
    dt_in = 1'b1;
    ck_in = 1'b1;
  end
  task automatic send(input int p, input logic [7:0] b, input logic stop);
    logic [9:0] fr;
    fr = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      dt_in <= fr[i];
      repeat (p) @(posedge clk);
    end
    dt_in <= 1'b1;
  endtask
  task automatic get(input int p, output logic [9:0] fr);
    int n;
    n = 0;
    while (line !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    repeat (p / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      fr[i] = line;
      repeat (p) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- bench/spcb_serial_port_checker.sv
// Purpose: port-level checks of the serial port block
// Assumes: sees only the top ports; port enable tracked from bus writes
// Notes: bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module spcb_serial_port_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire spcb_pkg::spcb_pins_t pins,
  input wire logic receive_interrupt_flag,
  input wire logic tx_buffer_empty
);
  logic en_r;
  logic rd_ok;
  assign rd_ok = avs_read && !avs_waitrequest;
  always_ff @(posedge clk) begin
    if (reset) begin
      en_r <= 1'b0;
    end else if (avs_write && avs_byteenable[0] && avs_address == spcb_pkg::OFS_RX_CTRL) begin
      en_r <= avs_writedata[spcb_pkg::RXC_PORT_EN];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read wait too long");
  a_read_hi_zero: assert property (rd_ok |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (rd_ok && avs_address > 5'h18 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_off_pins_free: assert property (!en_r |-> !pins.dt_oe && !pins.ck_oe)
    else $error("pins driven while off");
  a_off_flags_clear: assert property (!en_r |=> !receive_interrupt_flag && tx_buffer_empty)
    else $error("flags alive while off");
  a_rx_read_clears: assert property (rd_ok && avs_address == spcb_pkg::OFS_RX_DATA
    |=> !receive_interrupt_flag) else $error("flag kept after data read");
  a_tx_load: assert property (avs_write && avs_byteenable[0] && en_r && tx_buffer_empty
    && avs_address == spcb_pkg::OFS_TX_DATA |=> !tx_buffer_empty) else $error("tx not loaded");
  c_rx_char: cover property ($rose(receive_interrupt_flag));
  c_tx_busy: cover property ($fell(tx_buffer_empty));
  c_rx_read: cover property (rd_ok && avs_address == spcb_pkg::OFS_RX_DATA);
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: self-checking bench of the serial port block
// Assumes: async traffic only; peer loops bytes both ways
// Notes: byte enable tied to the low lane
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic reset;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic dt_in;
  logic ck_in;
  spcb_pkg::spcb_pins_t pins;
  logic receive_interrupt_flag;
  logic tx_buffer_empty;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h00005483;
  logic [7:0] q;
  logic [7:0] b;
  logic [9:0] f;
  logic [7:0] exp_q[$];
  int p;
  // divisor, baud ctrl, tx ctrl, clocks per bit
  logic [7:0] cfg [3][4] = '{'{8'h00, 8'h08, 8'h24, 8'h04}, '{8'h01, 8'h08, 8'h20, 8'h20},
    '{8'h00, 8'h00, 8'h20, 8'h40}};
  spcb_serial_port spcb_serial_port_i (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dt_in(dt_in), .ck_in(ck_in), .pins(pins), .receive_interrupt_flag(receive_interrupt_flag),
    .tx_buffer_empty(tx_buffer_empty));
  spcb_remote_peer peer_i (.clk(clk), .line(pins.ck_out), .dt_in(dt_in), .ck_in(ck_in));
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00);
    chk({24'h0, q}, {24'h0, e}, n);
  endtask
  task automatic rxget(input logic [7:0] st);
    int n;
    n = 0;
    while (receive_interrupt_flag !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    rd(spcb_pkg::OFS_RX_CTRL, st, "rx status");
    rd(spcb_pkg::OFS_RX_DATA, exp_q.pop_front(), "rx data");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(spcb_pkg::OFS_TX_CTRL, 8'h02, "tx ctrl");
    rd(spcb_pkg::OFS_BAUD_CTRL, 8'h40, "baud ctrl");
    rd(spcb_pkg::OFS_RX_CTRL, 8'h00, "rx ctrl");
    rd(5'h1c, 8'h00, "unmapped");
    bus(1'b1, spcb_pkg::OFS_RX_CTRL, 8'h80);
    for (int i = 0; i < 4; i++) begin
      b = xs() & 8'hf5;
      bus(1'b1, spcb_pkg::OFS_TX_CTRL, b);
      rd(spcb_pkg::OFS_TX_CTRL, b | 8'h02, "tx ctrl rw");
    end
    // back to async first: a sync receiver armed here would deliver junk later
    bus(1'b1, spcb_pkg::OFS_TX_CTRL, 8'h00);
    bus(1'b1, spcb_pkg::OFS_RX_CTRL, 8'h90);
    for (int c = 0; c < 3; c++) begin
      p = int'(cfg[c][3]);
      bus(1'b1, spcb_pkg::OFS_DIV_LO, cfg[c][0]);
      bus(1'b1, spcb_pkg::OFS_DIV_HI, 8'h00);
      bus(1'b1, spcb_pkg::OFS_BAUD_CTRL, cfg[c][1]);
      bus(1'b1, spcb_pkg::OFS_TX_CTRL, cfg[c][2]);
      b = xs();
      bus(1'b1, spcb_pkg::OFS_TX_DATA, b);
      peer_i.get(p, f);
      chk({22'h0, f}, {22'h0, 1'b1, b, 1'b0}, "tx frame");
      repeat (p) @(posedge clk);
      rd(spcb_pkg::OFS_TX_CTRL, cfg[c][2] | 8'h02, "shift empty");
      b = xs();
      exp_q.push_back(b);
      peer_i.send(p, b, 1'b1);
      rxget(8'h90);
      rd(spcb_pkg::OFS_BAUD_CTRL, cfg[c][1] | 8'h40, "rx idle");
    end
    exp_q.push_back(8'ha5);
    peer_i.send(p, 8'ha5, 1'b0);
    rxget(8'h94);
    exp_q.push_back(8'h3c);
    peer_i.send(p, 8'h3c, 1'b1);
    peer_i.send(p, 8'hc3, 1'b1);
    repeat (p) @(posedge clk);
    rxget(8'h92);
    bus(1'b1, spcb_pkg::OFS_RX_CTRL, 8'h80);
    rd(spcb_pkg::OFS_RX_CTRL, 8'h80, "overrun clear");
    bus(1'b1, spcb_pkg::OFS_TX_CTRL, 8'h28);
    bus(1'b1, spcb_pkg::OFS_TX_DATA, xs());
    peer_i.get(p, f);
    chk({23'h0, f[8:0]}, 32'h0, "break bits");
    repeat (30 * p) @(posedge clk);
    rd(spcb_pkg::OFS_TX_CTRL, 8'h22, "break done");
    bus(1'b1, spcb_pkg::OFS_RX_CTRL, 8'h00);
    rd(spcb_pkg::OFS_TX_CTRL, 8'h02, "off tx ctrl");
    rd(spcb_pkg::OFS_BAUD_CTRL, 8'h40, "off baud ctrl");
    bus(1'b1, spcb_pkg::OFS_RX_CTRL, 8'h50);
    rd(spcb_pkg::OFS_RX_CTRL, 8'h00, "off rx ctrl");
    final_report();
  end
endmodule
bind spcb_serial_port spcb_serial_port_checker spcb_chk_i (.clk(clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins),
  .receive_interrupt_flag(receive_interrupt_flag), .tx_buffer_empty(tx_buffer_empty));
`default_nettype wire

//--- rtl/spcb_pkg.sv
// Purpose: shared constants and types of the serial port control and baud generator
// Assumes: 32-bit Avalon-MM register access, one aligned word per register
// Notes: registers hold 8 significant bits in the low byte, upper bits read zero
package spcb_pkg;

  // register byte addresses
  localparam logic [4:0] OFS_TX_CTRL = 5'h00;
  localparam logic [4:0] OFS_RX_CTRL = 5'h04;
  localparam logic [4:0] OFS_BAUD_CTRL = 5'h08;
  localparam logic [4:0] OFS_DIV_LO = 5'h0c;
  localparam logic [4:0] OFS_DIV_HI = 5'h10;
  localparam logic [4:0] OFS_TX_DATA = 5'h14;
  localparam logic [4:0] OFS_RX_DATA = 5'h18;

  // transmit_control_status fields
  localparam int TXC_CLK_SRC = 7;
  localparam int TXC_NINE = 6;
  localparam int TXC_TX_EN = 5;
  localparam int TXC_SYNC = 4;
  localparam int TXC_BREAK = 3;
  localparam int TXC_HIGH_SPEED = 2;
  localparam int TXC_SHIFT_EMPTY = 1;
  localparam int TXC_NINTH = 0;

  // receive_control_status fields
  localparam int RXC_PORT_EN = 7;
  localparam int RXC_NINE = 6;
  localparam int RXC_SINGLE = 5;
  localparam int RXC_CONT = 4;
  localparam int RXC_ADDR_DET = 3;
  localparam int RXC_FRAME_ERR = 2;
  localparam int RXC_OVERRUN = 1;
  localparam int RXC_NINTH = 0;

  // baud_control fields
  localparam int BC_ABD_OVF = 7;
  localparam int BC_RX_IDLE = 6;
  localparam int BC_POLARITY = 4;
  localparam int BC_WIDE = 3;
  localparam int BC_WAKE = 1;
  localparam int BC_ABD_EN = 0;

  // writable bit masks and reset values
  localparam logic [7:0] TXC_WMASK = 8'hfd;
  localparam logic [7:0] RXC_WMASK = 8'hf8;
  localparam logic [7:0] BC_WMASK = 8'h1b;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;

  // baud timer overflows per bit period
  localparam logic [6:0] MULT_SLOW8 = 7'h40;
  localparam logic [6:0] MULT_MID = 7'h10;
  localparam logic [6:0] MULT_FAST = 7'h04;

  localparam logic [3:0] BREAK_ZERO_BITS = 4'hd;
  localparam logic [2:0] ABD_MORE_FALLS = 3'h4;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BREAK} spcb_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spcb_rx_state_t;
  typedef enum logic [1:0] {AB_OFF, AB_ARM, AB_MEAS} spcb_abd_state_t;

  typedef struct packed {
    logic dt_out;
    logic dt_oe;
    logic ck_out;
    logic ck_oe;
  } spcb_pins_t;

endpackage

//--- rtl/spcb_serial_port.sv
// Purpose: serial port control/status registers, baud timer, framing and pin control
// Assumes: 10 MHz clk, synchronous active-high reset, Avalon-MM slave with waitrequest
// Notes: single receive holding register, single transmit holding register
`timescale 1ns/1ps
`default_nettype none

module spcb_serial_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dt_in,
  input wire logic ck_in,
  output spcb_pkg::spcb_pins_t pins,
  output logic receive_interrupt_flag,
  output logic tx_buffer_empty
);

  logic [7:0] txc_r, rxc_r, bc_r;
  logic [15:0] div_r, bt_r, div_eff;
  logic rd_ack_r;
  logic [31:0] rdata_r;
  logic wr_ok, rd_take, div_wr, rxd_read;
  logic port_en, port_rst, sync_mode, master, pol, tick;
  logic [6:0] bit_ticks, tph_r, rph_r;
  logic dt_s1, dt_s2, dt_s3, ck_s1, ck_s2, ck_s3;
  logic dt_fall, ck_rise, ck_fall, bit_end, s_drive, s_sample, adv;
  spcb_pkg::spcb_tx_state_t tx_state_r;
  spcb_pkg::spcb_rx_state_t rx_state_r;
  spcb_pkg::spcb_abd_state_t ab_state_r;
  logic [8:0] hold_r, tsr_r, rsr_r;
  logic hold_full_r, tx_out_r, break_done, tx_run, tx_idle;
  logic [3:0] tx_cnt_r, rx_cnt_r;
  logic rx_en, rx_mid, deliver, accept, single_done, rx_framing_error_flag_r, rx_frame_bad;
  logic [7:0] rbuf_r, rx_byte;
  logic rx_ninth_r, rx_full_r, overrun_error_flag_r, rif_r, wake_hit;
  logic [9:0] ab_pre_r, ab_pre_max;
  logic [15:0] ab_val_r;
  logic [2:0] ab_falls_r;
  logic ab_done, ab_ovf_r, ab_wrap;

  // ---------------- register bus ----------------
  assign wr_ok = avs_write & avs_byteenable[0];
  assign rd_take = avs_read & rd_ack_r;
  assign avs_waitrequest = avs_read & ~rd_ack_r;
  assign avs_readdata = rdata_r;
  assign div_wr = wr_ok & ((avs_address == spcb_pkg::OFS_DIV_LO) |
                           (avs_address == spcb_pkg::OFS_DIV_HI));
  assign rxd_read = rd_take & (avs_address == spcb_pkg::OFS_RX_DATA);

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= avs_read & ~rd_ack_r;
    end
  end

  // read data is sampled one cycle ahead of the accepting edge
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read & ~rd_ack_r) begin
      rdata_r <= 32'h0000_0000;
      if (avs_address == spcb_pkg::OFS_TX_CTRL) begin
        rdata_r[7:0] <= txc_r;
        rdata_r[spcb_pkg::TXC_SHIFT_EMPTY] <= tx_idle;
      end else if (avs_address == spcb_pkg::OFS_RX_CTRL) begin
        rdata_r[7:0] <= rxc_r;
        rdata_r[spcb_pkg::RXC_FRAME_ERR] <= rx_framing_error_flag_r;
        rdata_r[spcb_pkg::RXC_OVERRUN] <= overrun_error_flag_r;
        rdata_r[spcb_pkg::RXC_NINTH] <= rx_ninth_r;
      end else if (avs_address == spcb_pkg::OFS_BAUD_CTRL) begin
        rdata_r[7:0] <= bc_r;
        rdata_r[spcb_pkg::BC_ABD_OVF] <= ab_ovf_r;
        rdata_r[spcb_pkg::BC_RX_IDLE] <= (rx_state_r == spcb_pkg::RX_IDLE);
      end else if (avs_address == spcb_pkg::OFS_DIV_LO) begin
        rdata_r[7:0] <= div_r[7:0];
      end else if (avs_address == spcb_pkg::OFS_DIV_HI) begin
        rdata_r[7:0] <= div_r[15:8];
      end else if (avs_address == spcb_pkg::OFS_RX_DATA) begin
        rdata_r[7:0] <= rbuf_r;
      end
    end
  end

  // ---------------- control registers ----------------
  assign port_en = rxc_r[spcb_pkg::RXC_PORT_EN];
  assign port_rst = reset | ~port_en;
  assign sync_mode = txc_r[spcb_pkg::TXC_SYNC];
  assign master = sync_mode & txc_r[spcb_pkg::TXC_CLK_SRC];
  assign pol = bc_r[spcb_pkg::BC_POLARITY];

  // a software write wins over any hardware clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      txc_r <= spcb_pkg::CTRL_RESET;
    end else if (wr_ok & (avs_address == spcb_pkg::OFS_TX_CTRL)) begin
      txc_r <= avs_writedata[7:0] & spcb_pkg::TXC_WMASK;
    end else if (!port_en) begin
      txc_r <= spcb_pkg::CTRL_RESET;
    end else if (break_done) begin
      txc_r[spcb_pkg::TXC_BREAK] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rxc_r <= spcb_pkg::CTRL_RESET;
    end else if (wr_ok & (avs_address == spcb_pkg::OFS_RX_CTRL)) begin
      rxc_r <= avs_writedata[7:0] & spcb_pkg::RXC_WMASK;
    end else if (!port_en) begin
      rxc_r <= spcb_pkg::CTRL_RESET;
    end else if (single_done) begin
      rxc_r[spcb_pkg::RXC_SINGLE] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bc_r <= spcb_pkg::CTRL_RESET;
    end else if (wr_ok & (avs_address == spcb_pkg::OFS_BAUD_CTRL)) begin
      bc_r <= avs_writedata[7:0] & spcb_pkg::BC_WMASK;
    end else if (!port_en) begin
      bc_r <= spcb_pkg::CTRL_RESET;
    end else begin
      if (wake_hit) begin
        bc_r[spcb_pkg::BC_WAKE] <= 1'b0;
      end
      if (ab_done) begin
        bc_r[spcb_pkg::BC_ABD_EN] <= 1'b0;
      end
    end
  end

  // divisor survives port disable so setup may precede enabling
  always_ff @(posedge clk) begin
    if (reset) begin
      div_r <= spcb_pkg::DIV_RESET;
    end else if (wr_ok & (avs_address == spcb_pkg::OFS_DIV_LO)) begin
      div_r[7:0] <= avs_writedata[7:0];
    end else if (wr_ok & (avs_address == spcb_pkg::OFS_DIV_HI)) begin
      div_r[15:8] <= avs_writedata[7:0];
    end else if (ab_done) begin
      div_r <= (ab_val_r == 16'h0000) ? 16'h0000 : ab_val_r - 16'h0001;
    end
  end

  // ---------------- baud timer ----------------
  assign div_eff = bc_r[spcb_pkg::BC_WIDE] ? div_r : {8'h00, div_r[7:0]};
  assign tick = port_en & (bt_r == div_eff);

  always_ff @(posedge clk) begin
    if (port_rst | div_wr) begin
      bt_r <= 16'h0000;
    end else if (tick) begin
      bt_r <= 16'h0000;
    end else begin
      bt_r <= bt_r + 16'h0001;
    end
  end

  // timer overflows per bit: 64, 16 or 4
  always_comb begin
    if (sync_mode) begin
      bit_ticks = spcb_pkg::MULT_FAST;
    end else if (bc_r[spcb_pkg::BC_WIDE]) begin
      bit_ticks = txc_r[spcb_pkg::TXC_HIGH_SPEED] ? spcb_pkg::MULT_FAST : spcb_pkg::MULT_MID;
    end else begin
      bit_ticks = txc_r[spcb_pkg::TXC_HIGH_SPEED] ? spcb_pkg::MULT_MID : spcb_pkg::MULT_SLOW8;
    end
  end

  always_ff @(posedge clk) begin
    if (port_rst) begin
      tph_r <= 7'h00;
    end else if (tick) begin
      tph_r <= (tph_r >= bit_ticks - 7'h01) ? 7'h00 : tph_r + 7'h01;
    end
  end
  assign bit_end = tick & (tph_r >= bit_ticks - 7'h01);

  // ---------------- pin synchronisers ----------------
  always_ff @(posedge clk) begin
    if (reset) begin
      {dt_s1, dt_s2, dt_s3} <= 3'h7;
      {ck_s1, ck_s2, ck_s3} <= 3'h7;
    end else begin
      {dt_s1, dt_s2, dt_s3} <= {dt_in, dt_s1, dt_s2};
      {ck_s1, ck_s2, ck_s3} <= {ck_in, ck_s1, ck_s2};
    end
  end
  assign dt_fall = dt_s3 & ~dt_s2;
  assign ck_rise = ~ck_s3 & ck_s2;
  assign ck_fall = ck_s3 & ~ck_s2;

  // master runs the shift clock off the baud timer, slave follows the pin
  assign s_drive = master ? bit_end : (pol ? ck_fall : ck_rise);
  assign s_sample = master ? (tick & (tph_r == 7'h01)) : (pol ? ck_rise : ck_fall);
  assign adv = sync_mode ? s_drive : bit_end;

  // ---------------- transmitter ----------------
  assign tx_run = txc_r[spcb_pkg::TXC_TX_EN] &
                  ~(sync_mode & (rxc_r[spcb_pkg::RXC_SINGLE] | rxc_r[spcb_pkg::RXC_CONT]));
  assign tx_idle = (tx_state_r == spcb_pkg::TX_IDLE);
  assign tx_buffer_empty = ~hold_full_r;
  assign break_done = (tx_state_r == spcb_pkg::TX_STOP) & adv & txc_r[spcb_pkg::TXC_BREAK] &
                      ~sync_mode;

  always_ff @(posedge clk) begin
    if (port_rst) begin
      hold_r <= 9'h000;
      hold_full_r <= 1'b0;
    end else if (wr_ok & (avs_address == spcb_pkg::OFS_TX_DATA) & ~hold_full_r) begin
      hold_r <= {txc_r[spcb_pkg::TXC_NINTH], avs_writedata[7:0]};
      hold_full_r <= 1'b1;
    end else if (tx_idle & adv & hold_full_r & tx_run) begin
      hold_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (port_rst) begin
      tx_state_r <= spcb_pkg::TX_IDLE;
      tsr_r <= 9'h000;
      tx_cnt_r <= 4'h0;
      tx_out_r <= 1'b1;
    end else if (adv) begin
      case (tx_state_r)
        spcb_pkg::TX_IDLE: begin
          if (hold_full_r & tx_run) begin
            tsr_r <= hold_r;
            tx_cnt_r <= 4'h0;
            if (sync_mode) begin
              tx_out_r <= hold_r[0];
              tsr_r <= {1'b0, hold_r[8:1]};
              tx_cnt_r <= txc_r[spcb_pkg::TXC_NINE] ? 4'h8 : 4'h7;
              tx_state_r <= spcb_pkg::TX_DATA;
            end else if (txc_r[spcb_pkg::TXC_BREAK]) begin
              tx_out_r <= 1'b0;
              tx_state_r <= spcb_pkg::TX_BREAK;
            end else begin
              tx_out_r <= 1'b0;
              tx_state_r <= spcb_pkg::TX_START;
            end
          end
        end
        spcb_pkg::TX_START: begin
          tx_out_r <= tsr_r[0];
          tsr_r <= {1'b0, tsr_r[8:1]};
          tx_cnt_r <= txc_r[spcb_pkg::TXC_NINE] ? 4'h8 : 4'h7;
          tx_state_r <= spcb_pkg::TX_DATA;
        end
        spcb_pkg::TX_DATA: begin
          if (tx_cnt_r == 4'h0) begin
            tx_out_r <= 1'b1;
            tx_state_r <= sync_mode ? spcb_pkg::TX_IDLE : spcb_pkg::TX_STOP;
          end else begin
            tx_out_r <= tsr_r[0];
            tsr_r <= {1'b0, tsr_r[8:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
          end
        end
        spcb_pkg::TX_BREAK: begin
          if (tx_cnt_r == spcb_pkg::BREAK_ZERO_BITS - 4'h1) begin
            tx_out_r <= 1'b1;
            tx_state_r <= spcb_pkg::TX_STOP;
          end else begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
          end
        end
        default: begin
          tx_state_r <= spcb_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // ---------------- receiver ----------------
  assign rx_en = ~overrun_error_flag_r & (sync_mode ?
                 (rxc_r[spcb_pkg::RXC_CONT] | (master & rxc_r[spcb_pkg::RXC_SINGLE])) :
                 (rxc_r[spcb_pkg::RXC_CONT] & ~bc_r[spcb_pkg::BC_WAKE] &
                  ~bc_r[spcb_pkg::BC_ABD_EN]));
  assign rx_mid = tick & (rph_r == (bit_ticks >> 1));
  assign rx_frame_bad = (rx_state_r == spcb_pkg::RX_STOP) & ~dt_s2;
  assign deliver = ((rx_state_r == spcb_pkg::RX_STOP) & rx_mid) |
                   (sync_mode & (rx_state_r == spcb_pkg::RX_DATA) & s_sample & (rx_cnt_r == 4'h0));
  // a nine-bit character has its last bit in the top of the shifter
  assign rx_byte = rxc_r[spcb_pkg::RXC_NINE] ? rsr_r[7:0] : rsr_r[8:1];
  assign accept = ~(~sync_mode & rxc_r[spcb_pkg::RXC_NINE] & rxc_r[spcb_pkg::RXC_ADDR_DET] &
                    ~rsr_r[8]);
  assign single_done = deliver & sync_mode & ~rxc_r[spcb_pkg::RXC_CONT];

  always_ff @(posedge clk) begin
    if (port_rst) begin
      rx_state_r <= spcb_pkg::RX_IDLE;
      rph_r <= 7'h00;
      rsr_r <= 9'h000;
      rx_cnt_r <= 4'h0;
    end else begin
      if (tick) begin
        rph_r <= (rph_r >= bit_ticks - 7'h01) ? 7'h00 : rph_r + 7'h01;
      end
      case (rx_state_r)
        spcb_pkg::RX_IDLE: begin
          if (rx_en & ~sync_mode & dt_fall) begin
            rph_r <= 7'h00;
            rx_state_r <= spcb_pkg::RX_START;
          end else if (rx_en & sync_mode & (master ? bit_end : 1'b1)) begin
            rx_cnt_r <= rxc_r[spcb_pkg::RXC_NINE] ? 4'h8 : 4'h7;
            rx_state_r <= spcb_pkg::RX_DATA;
          end
        end
        spcb_pkg::RX_START: begin
          if (rx_mid) begin
            rx_cnt_r <= rxc_r[spcb_pkg::RXC_NINE] ? 4'h8 : 4'h7;
            rx_state_r <= dt_s2 ? spcb_pkg::RX_IDLE : spcb_pkg::RX_DATA;
          end
        end
        spcb_pkg::RX_DATA: begin
          if (sync_mode ? s_sample : rx_mid) begin
            rsr_r <= {dt_s2, rsr_r[8:1]};
            rx_cnt_r <= rx_cnt_r - 4'h1;
            if (rx_cnt_r == 4'h0) begin
              rx_state_r <= sync_mode ? spcb_pkg::RX_IDLE : spcb_pkg::RX_STOP;
            end
          end
        end
        spcb_pkg::RX_STOP: begin
          if (rx_mid) begin
            rx_state_r <= spcb_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= spcb_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // the sync path delivers before the last shift lands, so it merges that bit here
  always_ff @(posedge clk) begin
    if (port_rst) begin
      rbuf_r <= 8'h00;
      rx_ninth_r <= 1'b0;
      rx_framing_error_flag_r <= 1'b0;
      rx_full_r <= 1'b0;
    // a character landing on the read edge refills the buffer rather than being lost
    end else if (deliver & accept & (~rx_full_r | rxd_read)) begin
      if (sync_mode) begin
        rbuf_r <= rxc_r[spcb_pkg::RXC_NINE] ? rsr_r[8:1] : {dt_s2, rsr_r[8:2]};
        rx_ninth_r <= rxc_r[spcb_pkg::RXC_NINE] & dt_s2;
      end else begin
        rbuf_r <= rx_byte;
        rx_ninth_r <= rxc_r[spcb_pkg::RXC_NINE] & rsr_r[8];
      end
      rx_framing_error_flag_r <= rx_frame_bad & ~sync_mode;
      rx_full_r <= 1'b1;
    end else if (rxd_read) begin
      rx_full_r <= 1'b0;
    end
  end

  // the overrun set wins over a continuous-receive clear in the same cycle
  always_ff @(posedge clk) begin
    if (port_rst) begin
      overrun_error_flag_r <= 1'b0;
    end else if (deliver & accept & rx_full_r & ~rxd_read) begin
      overrun_error_flag_r <= 1'b1;
    end else if (~rxc_r[spcb_pkg::RXC_CONT]) begin
      overrun_error_flag_r <= 1'b0;
    end
  end

  assign wake_hit = ~sync_mode & bc_r[spcb_pkg::BC_WAKE] & dt_fall;
  always_ff @(posedge clk) begin
    if (port_rst) begin
      rif_r <= 1'b0;
    end else if ((deliver & accept & (~rx_full_r | rxd_read)) | wake_hit | ab_done) begin
      rif_r <= 1'b1;
    end else if (rxd_read) begin
      rif_r <= 1'b0;
    end
  end
  assign receive_interrupt_flag = rif_r;

  // ---------------- auto-baud ----------------
  // measures eight bit times of a 0x55 character between its first and fifth falling edge
  assign ab_pre_max = {bit_ticks, 3'h0} - 10'h001;
  assign ab_wrap = (ab_state_r == spcb_pkg::AB_MEAS) & (ab_pre_r == ab_pre_max);
  assign ab_done = (ab_state_r == spcb_pkg::AB_MEAS) & dt_fall & (ab_falls_r == spcb_pkg::ABD_MORE_FALLS - 3'h1);

  always_ff @(posedge clk) begin
    if (port_rst | sync_mode | ~bc_r[spcb_pkg::BC_ABD_EN]) begin
      ab_state_r <= spcb_pkg::AB_OFF;
      ab_pre_r <= 10'h000;
      ab_val_r <= 16'h0000;
      ab_falls_r <= 3'h0;
    end else begin
      case (ab_state_r)
        spcb_pkg::AB_OFF: begin
          ab_state_r <= spcb_pkg::AB_ARM;
        end
        spcb_pkg::AB_ARM: begin
          if (dt_fall) begin
            ab_pre_r <= 10'h000;
            ab_val_r <= 16'h0000;
            ab_falls_r <= 3'h0;
            ab_state_r <= spcb_pkg::AB_MEAS;
          end
        end
        spcb_pkg::AB_MEAS: begin
          ab_pre_r <= ab_wrap ? 10'h000 : ab_pre_r + 10'h001;
          if (ab_wrap) begin
            ab_val_r <= ab_val_r + 16'h0001;
          end
          if (dt_fall) begin
            ab_falls_r <= ab_falls_r + 3'h1;
          end
          if (ab_done) begin
            ab_state_r <= spcb_pkg::AB_OFF;
          end
        end
        default: begin
          ab_state_r <= spcb_pkg::AB_OFF;
        end
      endcase
    end
  end

  // overflow stays set until the next auto-baud start or port disable
  always_ff @(posedge clk) begin
    if (port_rst) begin
      ab_ovf_r <= 1'b0;
    end else if (ab_wrap & (ab_val_r == 16'hffff) & ~sync_mode) begin
      ab_ovf_r <= 1'b1;
    end else if (wr_ok & (avs_address == spcb_pkg::OFS_BAUD_CTRL) &
                 avs_writedata[spcb_pkg::BC_ABD_EN]) begin
      ab_ovf_r <= 1'b0;
    end
  end

  // ---------------- pins ----------------
  always_comb begin
    pins.dt_out = tx_out_r;
    pins.dt_oe = port_en & sync_mode & ~tx_idle;
    pins.ck_out = tx_out_r ^ pol;
    pins.ck_oe = port_en & ~sync_mode;
    if (sync_mode) begin
      // clock toggles only while a master shift is under way
      pins.ck_out = ((~tx_idle | (rx_state_r != spcb_pkg::RX_IDLE)) & tph_r[1]) ~^ ~pol;
      pins.ck_oe = port_en & master;
    end
  end

endmodule

`default_nettype wire
